// ### design/trb_apb_slave.sv
// apb slave front end with one wait state and registered read data
`timescale 1ns/10ps
module trb_apb_slave (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [3:0]  paddr,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // core side
    input  wire logic [7:0]  rd_byte,
    output logic             acc_rd,
    output logic             acc_wr,
    output logic [1:0]       acc_idx
);
    logic        resp_ff;
    logic        nxt_resp;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic        err_ff;
    logic        nxt_err;
    logic        first;
    logic        bad;

    // first access cycle carries the action; pready follows a cycle later
    always_comb begin
        first     = psel && penable && !resp_ff;
        bad       = (paddr[1:0] != 2'h0);
        acc_idx   = paddr[3:2];
        acc_rd    = first && !pwrite && !bad;
        acc_wr    = first && pwrite && !bad;
        nxt_resp  = first;
        nxt_rdata = rdata_ff;
        nxt_err   = err_ff;
        if (first) begin
            nxt_err   = bad;
            nxt_rdata = (pwrite || bad) ? trb_pkg::RST_WORD : {24'h00_0000, rd_byte};
        end
    end

    // response registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resp_ff  <= 1'b0;
            rdata_ff <= trb_pkg::RST_WORD;
            err_ff   <= 1'b0;
        end else begin
            resp_ff  <= nxt_resp;
            rdata_ff <= nxt_rdata;
            err_ff   <= nxt_err;
        end
    end

    assign pready  = resp_ff;
    assign prdata  = rdata_ff;
    assign pslverr = resp_ff && err_ff;
endmodule

// ### design/trb_cw_decode.sv
// control word decoder: program, counter latch and read-back commands
`timescale 1ns/10ps
module trb_cw_decode (
    // control word byte
    input  wire logic [7:0] cw,
    // read-back command
    output logic            is_rb,
    output logic            rb_cnt_n,
    output logic            rb_sts_n,
    output logic [2:0]      rb_sel,
    // single counter commands, one-hot
    output logic [2:0]      prog_sel,
    output logic [2:0]      latch_sel,
    // programmed fields
    output logic [1:0]      fmt,
    output logic [2:0]      mode,
    output logic            bcd
);
    logic [1:0] sel;

    // field extraction and command split
    always_comb begin
        sel       = cw[trb_pkg::CW_SEL_LSB +: 2];
        fmt       = cw[trb_pkg::CW_FMT_LSB +: 2];
        mode      = cw[trb_pkg::CW_MODE_LSB +: 3];
        bcd       = cw[trb_pkg::CW_BCD_BIT];
        is_rb     = (sel == trb_pkg::SEL_RB);
        rb_cnt_n  = cw[trb_pkg::RB_CNT_N_BIT];
        rb_sts_n  = cw[trb_pkg::RB_STS_N_BIT];
        rb_sel    = is_rb ? cw[trb_pkg::RB_SEL_LSB +: 3] : 3'h0;
        prog_sel  = 3'h0;
        latch_sel = 3'h0;
        if (!is_rb) begin
            if (fmt == trb_pkg::FMT_LATCH) begin
                latch_sel[sel] = 1'b1;
            end else begin
                prog_sel[sel] = 1'b1;
            end
        end
    end
endmodule

// ### design/trb_pkg.sv
// constants shared by the timer count and status read-back block
package trb_pkg;
    // counters and bus widths
    localparam int          NUM_CNT      = 3;
    localparam int          ADDR_W       = 4;
    // register byte addresses: counters 0..2 then the control word
    localparam logic [3:0]  ADDR_CNT0    = 4'h0;
    localparam logic [3:0]  ADDR_CNT1    = 4'h4;
    localparam logic [3:0]  ADDR_CNT2    = 4'h8;
    localparam logic [3:0]  ADDR_CTRL    = 4'hC;
    localparam logic [1:0]  IDX_CTRL     = 2'h3;
    // control word field positions
    localparam int          CW_SEL_LSB   = 6;
    localparam int          CW_FMT_LSB   = 4;
    localparam int          CW_MODE_LSB  = 1;
    localparam int          CW_BCD_BIT   = 0;
    localparam int          RB_CNT_N_BIT = 5;
    localparam int          RB_STS_N_BIT = 4;
    localparam int          RB_SEL_LSB   = 1;
    localparam logic [1:0]  SEL_RB       = 2'h3;
    // byte access formats
    localparam logic [1:0]  FMT_LATCH    = 2'h0;
    localparam logic [1:0]  FMT_LSB      = 2'h1;
    localparam logic [1:0]  FMT_MSB      = 2'h2;
    localparam logic [1:0]  FMT_BOTH     = 2'h3;
    // status byte field positions
    localparam int          ST_OUT_BIT   = 7;
    localparam int          ST_NULL_BIT  = 6;
    localparam int          ST_FMT_LSB   = 4;
    localparam int          ST_MODE_LSB  = 1;
    localparam int          ST_BCD_BIT   = 0;
    // values after reset
    localparam logic [2:0]  RST_MODE     = 3'h0;
    localparam logic [1:0]  RST_FMT      = 2'h3;
    localparam logic [15:0] RST_HOLD     = 16'h0000;
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [31:0] RST_WORD     = 32'h0000_0000;
endpackage

// ### design/trb_top.sv
// timer count latch, read-back and byte sequencing for three counters
// Function
// - latch command copies the counter's present count into its holding latch
// - latched count stays frozen until fully read or counter reprogrammed
// - latching never stops counting nor changes the programmed mode
// - every counter has its own independent holding latch
// - latch command works for every counter regardless of gate
// - a second count latch before reading is ignored
// - byte read position kept across accesses to other counters
// - separate read and write byte order tracking per counter
// - read-back written at control word, read at counter addresses
// - read-back with count bit low latches counts of selected counters
// - read-back with status bit low latches status of selected counters
// - repeated status latch before status read is ignored
// - both bits low latch count and status together
// - status read first, then count bytes, then live count
// - control word selected when address bits 3:2 are both high and bits 1:0 are low
// - two control word bits set byte access format
`timescale 1ns/10ps
module trb_top (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // apb register bus
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [3:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic                  pready,
    output logic [31:0]           prdata,
    output logic                  pslverr,
    // live state from the counting elements
    input  wire logic [2:0][15:0] live_count,
    input  wire logic [2:0]       out_state,
    input  wire logic [2:0]       reload_pending,
    // programmed settings to the counting elements
    output logic [2:0][2:0]       cnt_mode,
    output logic [2:0][1:0]       cnt_fmt,
    output logic [2:0]            cnt_bcd,
    output logic [2:0]            prog_pulse,
    // count byte writes to the counting elements
    output logic [2:0]            load_pulse,
    output logic [7:0]            load_byte,
    output logic                  load_hi,
    // latch state visible for observation
    output logic [2:0]            cnt_latched,
    output logic [2:0]            sts_latched
);
    // bus side decode
    logic             acc_rd;
    logic             acc_wr;
    logic [1:0]       acc_idx;
    logic [7:0]       rd_byte;
    // control word decode
    logic             is_rb;
    logic             rb_cnt_n;
    logic             rb_sts_n;
    logic [2:0]       rb_sel;
    logic [2:0]       prog_sel;
    logic [2:0]       latch_sel;
    logic [1:0]       cw_fmt;
    logic [2:0]       cw_mode;
    logic             cw_bcd;
    logic             cw_wr;
    // per counter state
    logic [2:0][2:0]  mode_ff;
    logic [2:0][2:0]  nxt_mode;
    logic [2:0][1:0]  fmt_ff;
    logic [2:0][1:0]  nxt_fmt;
    logic [2:0]       bcd_ff;
    logic [2:0]       nxt_bcd;
    logic [2:0][15:0] hold_ff;
    logic [2:0][15:0] nxt_hold;
    logic [2:0]       cnt_lat_ff;
    logic [2:0]       nxt_cnt_lat;
    logic [2:0][7:0]  sts_ff;
    logic [2:0][7:0]  nxt_sts;
    logic [2:0]       sts_lat_ff;
    logic [2:0]       nxt_sts_lat;
    logic [2:0]       rd_hi_ff;
    logic [2:0]       nxt_rd_hi;
    logic [2:0]       wr_hi_ff;
    logic [2:0]       nxt_wr_hi;
    // registered outputs
    logic [2:0]       prog_ff;
    logic [2:0]       nxt_prog;
    logic [2:0]       load_ff;
    logic [2:0]       nxt_load;
    logic [7:0]       lbyte_ff;
    logic [7:0]       nxt_lbyte;
    logic             lhi_ff;
    logic             nxt_lhi;

    // pick one byte of a count word
    function automatic logic [7:0] pick_byte(input logic [15:0] val, input logic hi);
        pick_byte = hi ? val[15:8] : val[7:0];
    endfunction

    // next byte of a count read is the high one
    function automatic logic hi_next(input logic [1:0] fmt, input logic pos);
        hi_next = (fmt == trb_pkg::FMT_MSB) || ((fmt == trb_pkg::FMT_BOTH) && pos);
    endfunction

    // apb front end
    trb_apb_slave u_apb (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pready  (pready),
        .prdata  (prdata),
        .pslverr (pslverr),
        .rd_byte (rd_byte),
        .acc_rd  (acc_rd),
        .acc_wr  (acc_wr),
        .acc_idx (acc_idx)
    );

    // control word fields
    trb_cw_decode u_cw (
        .cw        (pwdata[7:0]),
        .is_rb     (is_rb),
        .rb_cnt_n  (rb_cnt_n),
        .rb_sts_n  (rb_sts_n),
        .rb_sel    (rb_sel),
        .prog_sel  (prog_sel),
        .latch_sel (latch_sel),
        .fmt       (cw_fmt),
        .mode      (cw_mode),
        .bcd       (cw_bcd)
    );

    // control word port sits at index three, both low select bits high
    assign cw_wr = acc_wr && (acc_idx == trb_pkg::IDX_CTRL);

    // read data mux; control word is write-only and reads as zero
    always_comb begin
        rd_byte = trb_pkg::RST_BYTE;
        for (int i = 0; i < trb_pkg::NUM_CNT; i++) begin
            if (acc_idx == 2'(i)) begin
                if (sts_lat_ff[i]) begin
                    rd_byte = sts_ff[i];
                end else if (cnt_lat_ff[i]) begin
                    rd_byte = pick_byte(hold_ff[i], hi_next(fmt_ff[i], rd_hi_ff[i]));
                end else begin
                    // unlatched reads follow the counting element
                    rd_byte = pick_byte(live_count[i], hi_next(fmt_ff[i], rd_hi_ff[i]));
                end
            end
        end
    end

    // per counter latch, status and byte order state
    always_comb begin
        nxt_mode    = mode_ff;
        nxt_fmt     = fmt_ff;
        nxt_bcd     = bcd_ff;
        nxt_hold    = hold_ff;
        nxt_cnt_lat = cnt_lat_ff;
        nxt_sts     = sts_ff;
        nxt_sts_lat = sts_lat_ff;
        nxt_rd_hi   = rd_hi_ff;
        nxt_wr_hi   = wr_hi_ff;
        nxt_prog    = 3'h0;
        nxt_load    = 3'h0;
        nxt_lbyte   = lbyte_ff;
        nxt_lhi     = lhi_ff;
        for (int i = 0; i < trb_pkg::NUM_CNT; i++) begin
            // control word programs one counter and drops its latches
            if (cw_wr && prog_sel[i]) begin
                nxt_mode[i]    = cw_mode;
                nxt_fmt[i]     = cw_fmt;
                nxt_bcd[i]     = cw_bcd;
                nxt_cnt_lat[i] = 1'b0;
                nxt_sts_lat[i] = 1'b0;
                nxt_rd_hi[i]   = 1'b0;
                nxt_wr_hi[i]   = 1'b0;
                nxt_prog[i]    = 1'b1;
            end
            // count latch, single command or read-back; mode untouched
            if (cw_wr && (latch_sel[i] || (is_rb && !rb_cnt_n && rb_sel[i]))) begin
                if (!cnt_lat_ff[i]) begin
                    nxt_hold[i]    = live_count[i];
                    nxt_cnt_lat[i] = 1'b1;
                end
            end
            // status latch; first request wins until the status is read
            if (cw_wr && is_rb && !rb_sts_n && rb_sel[i] && !sts_lat_ff[i]) begin
                nxt_sts[i][trb_pkg::ST_OUT_BIT]         = out_state[i];
                nxt_sts[i][trb_pkg::ST_NULL_BIT]        = reload_pending[i];
                nxt_sts[i][trb_pkg::ST_FMT_LSB +: 2]    = fmt_ff[i];
                nxt_sts[i][trb_pkg::ST_MODE_LSB +: 3]   = mode_ff[i];
                nxt_sts[i][trb_pkg::ST_BCD_BIT]         = bcd_ff[i];
                nxt_sts_lat[i]                          = 1'b1;
            end
            // reads: status first, then one or two count bytes
            if (acc_rd && (acc_idx == 2'(i))) begin
                if (sts_lat_ff[i]) begin
                    nxt_sts_lat[i] = 1'b0;
                end else begin
                    if (fmt_ff[i] == trb_pkg::FMT_BOTH) begin
                        nxt_rd_hi[i] = !rd_hi_ff[i];
                    end
                    // unlatch once the last byte of the format is taken
                    if (fmt_ff[i] != trb_pkg::FMT_BOTH || rd_hi_ff[i]) begin
                        nxt_cnt_lat[i] = 1'b0;
                    end
                end
            end
            // count byte writes keep their own order bit
            if (acc_wr && (acc_idx == 2'(i))) begin
                nxt_load[i] = 1'b1;
                nxt_lbyte   = pwdata[7:0];
                nxt_lhi     = hi_next(fmt_ff[i], wr_hi_ff[i]);
                if (fmt_ff[i] == trb_pkg::FMT_BOTH) begin
                    nxt_wr_hi[i] = !wr_hi_ff[i];
                end
            end
        end
    end

    // state registers; a read clear comes after a latch set and would win it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < trb_pkg::NUM_CNT; i++) begin
                mode_ff[i] <= trb_pkg::RST_MODE;
                fmt_ff[i]  <= trb_pkg::RST_FMT;
                hold_ff[i] <= trb_pkg::RST_HOLD;
                sts_ff[i]  <= trb_pkg::RST_BYTE;
            end
            bcd_ff     <= 3'h0;
            cnt_lat_ff <= 3'h0;
            sts_lat_ff <= 3'h0;
            rd_hi_ff   <= 3'h0;
            wr_hi_ff   <= 3'h0;
            prog_ff    <= 3'h0;
            load_ff    <= 3'h0;
            lbyte_ff   <= trb_pkg::RST_BYTE;
            lhi_ff     <= 1'b0;
        end else begin
            mode_ff    <= nxt_mode;
            fmt_ff     <= nxt_fmt;
            bcd_ff     <= nxt_bcd;
            hold_ff    <= nxt_hold;
            cnt_lat_ff <= nxt_cnt_lat;
            sts_ff     <= nxt_sts;
            sts_lat_ff <= nxt_sts_lat;
            rd_hi_ff   <= nxt_rd_hi;
            wr_hi_ff   <= nxt_wr_hi;
            prog_ff    <= nxt_prog;
            load_ff    <= nxt_load;
            lbyte_ff   <= nxt_lbyte;
            lhi_ff     <= nxt_lhi;
        end
    end

    // outputs straight from registers
    assign cnt_mode    = mode_ff;
    assign cnt_fmt     = fmt_ff;
    assign cnt_bcd     = bcd_ff;
    assign prog_pulse  = prog_ff;
    assign load_pulse  = load_ff;
    assign load_byte   = lbyte_ff;
    assign load_hi     = lhi_ff;
    assign cnt_latched = cnt_lat_ff;
    assign sts_latched = sts_lat_ff;
endmodule

// ### verif/timer_count_status_readback_tb.sv
// self-checking bench for the timer count and status read-back block
`timescale 1ns/10ps
module timer_count_status_readback_tb;
    localparam logic [3:0] C0 = trb_pkg::ADDR_CNT0;
    localparam logic [3:0] C1 = trb_pkg::ADDR_CNT1;
    localparam logic [3:0] C2 = trb_pkg::ADDR_CNT2;
    localparam logic [3:0] CW = trb_pkg::ADDR_CTRL;
    // design and model connections
    logic                  pclk = 1'b0;
    logic                  presetn, psel, penable, pwrite, pready, pslverr, load_hi;
    logic [3:0]            paddr;
    logic [31:0]           pwdata, prdata, rd;
    logic [2:0][15:0]      live_count, act_cnt;
    logic [2:0][2:0]       cnt_mode;
    logic [2:0][1:0]       cnt_fmt;
    logic [2:0]            cnt_bcd, prog_pulse, load_pulse, out_state, reload_pending;
    logic [2:0]            cnt_latched, sts_latched, act_out, act_rel, lpul;
    logic [7:0]            load_byte, lbyte;
    logic                  perr, lhi;
    logic [15:0]           lat [3];
    logic [1:0]            st [3];
    int                    fail_count = 0;
    int                    comparisons = 0;
    string                 tname;

    always #50 pclk = ~pclk;
    // live state at the edge where the slave acts
    always @(posedge pclk) if (psel && penable && !pready) begin
        act_cnt <= live_count;
        act_out <= out_state;
        act_rel <= reload_pending;
    end

    trb_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .live_count(live_count), .out_state(out_state),
        .reload_pending(reload_pending), .cnt_mode(cnt_mode), .cnt_fmt(cnt_fmt),
        .cnt_bcd(cnt_bcd), .prog_pulse(prog_pulse), .load_pulse(load_pulse),
        .load_byte(load_byte), .load_hi(load_hi), .cnt_latched(cnt_latched),
        .sts_latched(sts_latched));
    trb_count_model model (.pclk(pclk), .presetn(presetn), .prog_pulse(prog_pulse),
        .load_pulse(load_pulse), .load_byte(load_byte), .load_hi(load_hi),
        .live_count(live_count), .out_state(out_state), .reload_pending(reload_pending));

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, tname, got, exp);
            fail_count++;
        end
    endtask
    // one apb transfer, entered right after an edge; holds until pready is sampled
    task automatic apb(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 8);
        if (pready !== 1'b1) begin
            fail_count++;
            report_and_stop();
        end
        rd = prdata;
        perr = pslverr;
        lpul = load_pulse;
        lbyte = load_byte;
        lhi = load_hi;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // count writes must reach the counting element with pready
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic hi);
        apb(1'b1, a, d);
        if (a != CW) chk({lpul, lhi, lbyte}, {3'h1 << a[3:2], hi, d});
    endtask
    task automatic rdv(input logic [3:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(rd, e);
    endtask
    // unlatched read: byte of the live count at the acting edge
    task automatic rdl(input int i, input logic hi);
        apb(1'b0, 4'(i * 4), 8'h00);
        chk(rd, hi ? act_cnt[i][15:8] : act_cnt[i][7:0]);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 4'h0;
        pwdata = 32'h0000_0000;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        tname = "reset";
        chk({cnt_fmt, cnt_mode, cnt_latched, sts_latched}, {6'h3f, 9'h0, 6'h0});
        $display("test %s done", tname);
        tname = "latch";
        wr(CW, 8'h34, 1'b0);
        chk({cnt_fmt[0], cnt_mode[0]}, {2'h3, 3'h2});
        wr(C0, 8'h34, 1'b0);
        wr(C0, 8'h12, 1'b1);
        wr(CW, 8'h00, 1'b0);
        lat[0] = act_cnt[0];
        wr(CW, 8'h00, 1'b0);
        repeat (5) @(posedge pclk);
        chk({cnt_mode[0], cnt_fmt[0]}, {3'h2, 2'h3});
        rdv(C0, lat[0][7:0]);
        chk(live_count[0] != lat[0], 1);
        rdv(C0, lat[0][15:8]);
        rdl(0, 1'b0);
        rdl(0, 1'b1);
        wr(CW, 8'h00, 1'b0);
        wr(CW, 8'h34, 1'b0);
        chk(cnt_latched, 3'h0);
        $display("test %s done", tname);
        tname = "multi";
        wr(CW, 8'h50, 1'b0);
        wr(CW, 8'hA7, 1'b0);
        chk({cnt_fmt[2], cnt_mode[2], cnt_bcd[2]}, {2'h2, 3'h3, 1'b1});
        wr(CW, 8'h40, 1'b0);
        lat[1] = act_cnt[1];
        wr(CW, 8'h80, 1'b0);
        lat[2] = act_cnt[2];
        wr(CW, 8'h00, 1'b0);
        lat[0] = act_cnt[0];
        chk(cnt_latched, 3'h7);
        rdv(C0, lat[0][7:0]);
        wr(C0, 8'h9A, 1'b0);
        rdv(C2, lat[2][15:8]);
        rdv(C1, lat[1][7:0]);
        rdv(C0, lat[0][15:8]);
        wr(C0, 8'h56, 1'b1);
        chk(cnt_latched, 3'h0);
        $display("test %s done", tname);
        tname = "readback";
        wr(CW, 8'hCE, 1'b0);
        for (int i = 0; i < 3; i++) begin
            lat[i] = act_cnt[i];
            st[i] = {act_out[i], act_rel[i]};
        end
        wr(CW, 8'hEE, 1'b0);
        wr(CW, 8'hCE, 1'b0);
        rdv(C0, {st[0], 6'h34});
        rdv(C0, lat[0][7:0]);
        rdv(C0, lat[0][15:8]);
        rdl(0, 1'b0);
        rdl(0, 1'b1);
        rdv(C1, {st[1], 6'h10});
        rdv(C1, lat[1][7:0]);
        rdv(C2, {st[2], 6'h27});
        rdv(C2, lat[2][15:8]);
        $display("test %s done", tname);
        tname = "order";
        wr(CW, 8'hD2, 1'b0);
        lat[0] = act_cnt[0];
        wr(CW, 8'hE2, 1'b0);
        rdv(C0, {act_out[0], act_rel[0], 6'h34});
        rdv(C0, lat[0][7:0]);
        rdv(C0, lat[0][15:8]);
        $display("test %s done", tname);
        tname = "refused";
        apb(1'b0, 4'h2, 8'h00);
        chk({perr, rd}, {1'b1, 32'h0000_0000});
        apb(1'b0, CW, 8'h00);
        chk({perr, rd}, 33'h0);
        // misaligned control word address would latch counter 0 if decoded
        apb(1'b1, 4'hF, 8'h00);
        chk({perr, cnt_latched, lpul}, {1'b1, 3'h0, 3'h0});
        $display("test %s done", tname);
        report_and_stop();
    end
endmodule

// ### verif/trb_count_model.sv
// behavioural counting elements feeding the read-back block
`timescale 1ns/10ps
module trb_count_model (
    // clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // from the block
    input wire logic [2:0]        prog_pulse,
    input wire logic [2:0]        load_pulse,
    input wire logic [7:0]        load_byte,
    input wire logic              load_hi,
    // live state to the block
    output logic [2:0][15:0]      live_count,
    output logic [2:0]            out_state,
    output logic [2:0]            reload_pending
);
    // counts every clock, so a frozen latch differs from the live value
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            live_count     <= '0;
            reload_pending <= '0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                live_count[i] <= live_count[i] - 16'h0001;
                if (prog_pulse[i]) reload_pending[i] <= 1'b1;
                if (load_pulse[i]) begin
                    reload_pending[i] <= 1'b0;
                    if (load_hi) live_count[i][15:8] <= load_byte;
                    else live_count[i][7:0] <= load_byte;
                end
            end
        end
    end
    // output level toggles often so the status byte varies
    assign out_state = {live_count[2][4], live_count[1][4], live_count[0][4]};
endmodule

// ### verif/trb_top_monitor.sv
// concurrent checks on the ports of the read-back block
`timescale 1ns/10ps
module trb_top_monitor (
    // clock and reset
    input wire logic             pclk,
    input wire logic             presetn,
    // apb
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [3:0]       paddr,
    input wire logic [31:0]      pwdata,
    input wire logic             pready,
    input wire logic [31:0]      prdata,
    input wire logic             pslverr,
    // core outputs
    input wire logic [2:0][2:0]  cnt_mode,
    input wire logic [2:0][1:0]  cnt_fmt,
    input wire logic [2:0]       prog_pulse,
    input wire logic [2:0]       load_pulse,
    input wire logic [7:0]       load_byte,
    input wire logic [2:0]       cnt_latched,
    input wire logic [2:0]       sts_latched
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // first access cycle, the edge where the slave acts
    logic act;
    logic cw_wr;
    assign act   = psel && penable && !pready;
    assign cw_wr = act && pwrite && paddr == trb_pkg::ADDR_CTRL;
    wait_one_a: assert property (act |=> pready) else $error("pready not after one wait");
    pulse_one_a: assert property (pready |=> !pready) else $error("pready held too long");
    err_decode_a: assert property (pready |-> pslverr == (paddr[1:0] != 2'h0))
        else $error("pslverr wrong for address");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper data");
    latch_set_a: assert property (cw_wr && pwdata[7:6] != 2'h3 && pwdata[5:4] == 2'h0
        |=> cnt_latched[pwdata[7:6]]) else $error("count latch not held");
    mode_kept_a: assert property (cw_wr && pwdata[7:6] != 2'h3 && pwdata[5:4] == 2'h0
        |=> $stable(cnt_mode) && $stable(cnt_fmt) && !prog_pulse) else $error("mode changed");
    prog_sets_a: assert property (cw_wr && pwdata[7:6] != 2'h3 && pwdata[5:4] != 2'h0
        |=> prog_pulse[pwdata[7:6]] && cnt_fmt[pwdata[7:6]] == pwdata[5:4]
        && cnt_mode[pwdata[7:6]] == pwdata[3:1]) else $error("program fields wrong");
    reprog_clr_a: assert property (cw_wr && pwdata[7:6] != 2'h3 && pwdata[5:4] != 2'h0
        |=> !cnt_latched[pwdata[7:6]]) else $error("latch kept over reprogram");
    rb_count_a: assert property (cw_wr && pwdata[7:6] == 2'h3 && !pwdata[5] && pwdata[1]
        |=> cnt_latched[0]) else $error("read-back count latch missing");
    rb_status_a: assert property (cw_wr && pwdata[7:6] == 2'h3 && !pwdata[4] && pwdata[3]
        |=> sts_latched[2]) else $error("read-back status latch missing");
    load_byte_a: assert property (act && pwrite && paddr == trb_pkg::ADDR_CNT0
        |=> load_pulse == 3'h1 && load_byte == pwdata[7:0]) else $error("count write lost");
    latch_hold_a: assert property (cnt_latched[0] && !act |=> cnt_latched[0])
        else $error("latch dropped without access");
    sts_first_a: assert property (act && !pwrite && paddr == trb_pkg::ADDR_CNT0 && sts_latched[0]
        |=> !sts_latched[0] && $stable(cnt_latched)) else $error("status not read first");
    // main scenarios reached
    cover property (cw_wr && pwdata[7:6] == 2'h3);
    cover property (pready && pslverr);
    cover property (act && !pwrite && cnt_latched[0]);
endmodule

bind trb_top trb_top_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .cnt_mode(cnt_mode), .cnt_fmt(cnt_fmt),
    .prog_pulse(prog_pulse), .load_pulse(load_pulse), .load_byte(load_byte),
    .cnt_latched(cnt_latched), .sts_latched(sts_latched));
